// ### core/power_mode_pkg.sv
// Constants and types for the power mode controller
package power_mode_pkg;

  // ---------------------------------------------------------------
  // Register map (word offsets are byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
  localparam logic [7:0] WAKE_CFG_OFS = 8'h04;
  localparam logic [7:0] WAKE_FLAG_OFS = 8'h08;
  localparam logic [7:0] CYC_CFG_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] FAIL_OFS = 8'h14;
  localparam logic [7:0] RETAIN0_OFS = 8'h18;
  localparam logic [7:0] RETAIN1_OFS = 8'h1C;

  // Mode control bits
  localparam int MODE_STOP_BIT = 0;
  localparam int MODE_SLEEP_BIT = 1;
  localparam int MODE_SLOW_BIT = 2;
  localparam int MODE_CYC_BIT = 3;

  // Wake configuration fields
  localparam int WCFG_LIN_BIT = 0;
  localparam int WCFG_MON_BIT = 1;
  localparam int WCFG_EDGE_POS = 2; // 2 bits
  localparam int WCFG_GPIO_POS = 8; // GPIO enables
  localparam logic [31:0] WAKE_CFG_RESET = 32'h0000_000E; // mon, both

  // Monitor edge selections
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Wake flag positions
  localparam int WFLAG_LIN_BIT = 0;
  localparam int WFLAG_MON_BIT = 1;
  localparam int WFLAG_CYC_BIT = 2;
  localparam int WFLAG_GPIO_POS = 8;

  // Cyclic period: milliseconds, largest setting after power-on
  localparam logic [15:0] CYC_MS_MAX = 16'hFFFF;
  localparam int FAILSAFE_WAKE_MS = 1000;
  localparam logic [15:0] FAILSAFE_MS = 16'(FAILSAFE_WAKE_MS);
  localparam int CLK_MHZ = 100;
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam int FAIL_LIMIT = 5;

  typedef enum logic [2:0] {
    M_RESET, M_ACTIVE, M_STOP, M_SLEEP
  } mode_t;

  // Supply and clock controls driven out
  typedef struct packed {
    logic supplies_on;
    logic hold_init;
    logic mcu_supply_on;
    logic mcu_supply_low;
    logic pll_on;
    logic slow_clock;
    logic regulator_on;
    logic measure_on;
    logic lin_keep;
  } power_ctl_t;

endpackage

// ### core/system_power_mode_controller.sv
// Power mode sequencer with wake latching and fail-safe sleep
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module system_power_mode_controller #(
  parameter int GPIO_N = 4,
  parameter int MS_CYC = power_mode_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic POR_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Status pins from supplies and watchdog
  input wire logic CORE_SUPPLY_RAIL_OK,
  input wire logic PRIMARY_WINDOW_WATCHDOG_FAIL,
  input wire logic SUPPLY_FAIL,
  // Wake sources
  input wire logic LIN_WAKE,
  input wire logic HIGH_VOLTAGE_MONITOR_INPUT,
  input wire logic [GPIO_N-1:0] GPIO_WAKE,
  // Power controls
  output power_mode_pkg::power_ctl_t POWER_CTL,
  output power_mode_pkg::mode_t MODE
);
  import power_mode_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Every status and wake pin is asynchronous to the reference clock. Two stages
  // per pin keep metastability away from the decoding logic.
  localparam int SN = GPIO_N + 5;
  // Two stages per pin; only the second stage feeds logic
  logic [SN-1:0] s1;
  logic [SN-1:0] s2;
  // Monitor level one cycle back, for edge detection
  logic mon_prev;

  always_ff @(posedge REF_CLK) begin
    s1 <= {GPIO_WAKE, HIGH_VOLTAGE_MONITOR_INPUT, LIN_WAKE,
           CORE_SUPPLY_RAIL_OK, PRIMARY_WINDOW_WATCHDOG_FAIL, SUPPLY_FAIL};
    s2 <= s1;
    mon_prev <= s2[4];
  end

  // Synchronised copies, named by what they carry
  logic sup_fail;
  logic wdt_fail;
  logic rail_ok;
  logic lin_s;
  logic mon_s;
  logic [GPIO_N-1:0] gpio_s;
  assign sup_fail = s2[0];
  assign wdt_fail = s2[1];
  assign rail_ok = s2[2];
  assign lin_s = s2[3];
  assign mon_s = s2[4];
  assign gpio_s = s2[SN-1:5];

  // Failure edges, so a held fault counts once
  logic wdt_prev;
  logic sup_prev;
  always_ff @(posedge REF_CLK) begin
    wdt_prev <= wdt_fail;
    sup_prev <= sup_fail;
  end

  // A fault that stays high is one failure, not one per cycle
  logic wdt_ev;
  logic sup_ev;
  assign wdt_ev = wdt_fail & ~wdt_prev;
  assign sup_ev = sup_fail & ~sup_prev;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Wake, cyclic and retained settings follow only power-on reset,
  // so a system reset after a wake does not undo software setup.
  mode_t mode;
  logic [3:0] mode_ctrl;
  logic [31:0] wake_cfg;
  logic [15:0] cyc_ms;
  logic [31:0] retain0;
  logic [31:0] retain1;
  // Consecutive failure counts and the fail-safe entry strobe
  logic [2:0] wdt_cnt;
  logic [2:0] sup_cnt;
  logic failsafe_go;
  logic failsafe;
  logic [31:0] wake_flag;
  logic cyc_on;

  function automatic logic hit(input logic [7:0] ofs);
    return WR && ADDR == ofs;
  endfunction

  // Mode request bits; stop and sleep are consumed when the transition starts, slow and cyclic are kept
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      mode_ctrl <= 4'h0;
    end else if (hit(MODE_CTRL_OFS)) begin
      mode_ctrl <= WDATA[3:0];
    end else if (mode == M_ACTIVE &&
                 (mode_ctrl[MODE_STOP_BIT] | mode_ctrl[MODE_SLEEP_BIT])) begin
      mode_ctrl <= {mode_ctrl[3:2], 2'h0};
    end
  end

  // Wake and cyclic configuration; defaults only on power-on reset
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      wake_cfg <= WAKE_CFG_RESET;
      cyc_ms <= CYC_MS_MAX;
      cyc_on <= 1'b1;
    end else if (failsafe_go) begin
      wake_cfg[WCFG_MON_BIT] <= 1'b1;
      cyc_ms <= FAILSAFE_MS;
      cyc_on <= 1'b1;
    end else begin
      // Software owns the settings between fail-safe entries
      if (hit(WAKE_CFG_OFS)) begin
        wake_cfg <= WDATA;
      end
      if (hit(CYC_CFG_OFS)) begin
        cyc_ms <= WDATA[15:0];
        cyc_on <= WDATA[16];
      end
    end
  end

  // Retained registers survive sleep; only power-on clears them
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      retain0 <= 32'h0;
      retain1 <= 32'h0;
    end else begin
      if (hit(RETAIN0_OFS)) begin
        retain0 <= WDATA;
      end
      if (hit(RETAIN1_OFS)) begin
        retain1 <= WDATA;
      end
    end
  end

  // ---------------------------------------------------------------
  // Consecutive failure counting
  // ---------------------------------------------------------------
  // Only reset and active can be forced; in a low-power mode the
  // watchdog is not running, and a fault there still counts but cannot force sleep
  assign failsafe_go = (mode == M_RESET || mode == M_ACTIVE) &&
    ((wdt_ev && wdt_cnt == 3'(FAIL_LIMIT - 1)) ||
     (sup_ev && sup_cnt == 3'(FAIL_LIMIT - 1)));

  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      wdt_cnt <= 3'h0;
      sup_cnt <= 3'h0;
    end else if (failsafe_go || (mode == M_RESET && rail_ok)) begin
      wdt_cnt <= 3'h0;
      sup_cnt <= 3'h0;
    end else begin
      if (wdt_ev) begin
        wdt_cnt <= wdt_cnt + 3'h1;
      end
      if (sup_ev) begin
        sup_cnt <= sup_cnt + 3'h1;
      end
    end
  end

  // Reached active normally only when no failure is pending this cycle
  // Entry wins over the clear, so a forced sleep is never lost
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      failsafe <= 1'b0;
    end else if (failsafe_go) begin
      failsafe <= 1'b1;
    end else if (mode == M_ACTIVE) begin
      failsafe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Cyclic wake timer, one millisecond tick
  // ---------------------------------------------------------------
  // The count restarts on every low-power entry, so each period is
  // measured from the moment the mode was entered.
  logic [31:0] tick_cnt;
  logic [15:0] ms_cnt;
  // Low-power flag and the period-elapsed wake
  logic low_power;
  logic cyc_wake;
  assign low_power = mode == M_STOP || mode == M_SLEEP;
  assign cyc_wake = low_power && cyc_on && ms_cnt >= cyc_ms &&
                    cyc_ms != 16'h0;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N || !low_power) begin
      tick_cnt <= 32'h0;
      ms_cnt <= 16'h0;
    end else if (tick_cnt == 32'(MS_CYC - 1)) begin
      tick_cnt <= 32'h0;
      ms_cnt <= ms_cnt + 16'h1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Wake detection and flags
  // ---------------------------------------------------------------
  // Monitor edges, then the enabled events per source
  logic mon_rise;
  logic mon_fall;
  logic mon_ev;
  logic lin_ev;
  logic [GPIO_N-1:0] gpio_ev;
  logic [1:0] edge_sel;
  assign edge_sel = wake_cfg[WCFG_EDGE_POS +: 2];
  assign mon_rise = mon_s & ~mon_prev;
  assign mon_fall = ~mon_s & mon_prev;
  assign mon_ev = wake_cfg[WCFG_MON_BIT] &&
    ((edge_sel[0] && mon_rise) || (edge_sel[1] && mon_fall));
  assign lin_ev = wake_cfg[WCFG_LIN_BIT] && lin_s;
  // GPIO wake is a stop-mode source only
  assign gpio_ev = (mode == M_STOP) ?
    (gpio_s & wake_cfg[WCFG_GPIO_POS +: GPIO_N]) : '0;

  logic [31:0] wake_set;
  always_comb begin
    wake_set = 32'h0;
    if (low_power) begin
      wake_set[WFLAG_LIN_BIT] = lin_ev;
      wake_set[WFLAG_MON_BIT] = mon_ev;
      wake_set[WFLAG_CYC_BIT] = cyc_wake;
      wake_set[WFLAG_GPIO_POS +: GPIO_N] = gpio_ev;
    end
  end

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      wake_flag <= 32'h0;
    end else if (hit(WAKE_FLAG_OFS)) begin
      wake_flag <= (wake_flag & ~WDATA) | wake_set;
    end else begin
      // Flags hold until cleared; events after the wake has left stop or sleep do not latch
      wake_flag <= wake_flag | wake_set;
    end
  end

  // Any source alone starts the wake sequence
  logic wake_any;
  assign wake_any = |wake_set;

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  // Fail-safe entry overrides any pending request. Sleep wakes
  // through reset mode so the supplies restart in order; stop
  // keeps the MCU powered and returns straight to active.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      mode <= M_RESET;
    end else if (failsafe_go) begin
      mode <= M_SLEEP;
    end else begin
      unique case (mode)
        M_RESET: begin
          // Wait for the core rail before releasing modules
          if (rail_ok) begin
            mode <= M_ACTIVE;
          end
        end
        M_ACTIVE: begin
          // Sleep bit wins, with or without the stop bit
          if (mode_ctrl[MODE_SLEEP_BIT]) begin
            mode <= M_SLEEP;
          end else if (mode_ctrl[MODE_STOP_BIT]) begin
            mode <= M_STOP;
          end
        end
        M_STOP: begin
          // First source to fire ends the stop
          if (wake_any) begin
            mode <= M_ACTIVE;
          end
        end
        M_SLEEP: begin
          // Regulator restarts through reset mode
          if (wake_any) begin
            mode <= M_RESET;
          end
        end
        default: mode <= M_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power controls, registered
  // ---------------------------------------------------------------
  // Every control is a flop, so the pins never glitch while the
  // sequencer moves; the price is one cycle behind the mode.
  // Reset keeps the supplies up so that modules can initialise.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      POWER_CTL <= '0;
      POWER_CTL.supplies_on <= 1'b1;
      POWER_CTL.hold_init <= 1'b1;
      POWER_CTL.mcu_supply_on <= 1'b1;
      POWER_CTL.regulator_on <= 1'b1;
      MODE <= M_RESET;
    end else begin
      MODE <= mode;
      POWER_CTL.supplies_on <= mode != M_SLEEP;
      POWER_CTL.hold_init <= mode == M_RESET;
      POWER_CTL.mcu_supply_on <= mode != M_SLEEP;
      POWER_CTL.mcu_supply_low <= mode == M_STOP;
      POWER_CTL.pll_on <= mode == M_ACTIVE;
      POWER_CTL.regulator_on <= mode != M_SLEEP;
      POWER_CTL.measure_on <= mode == M_ACTIVE;
      POWER_CTL.slow_clock <= mode == M_ACTIVE &&
                              mode_ctrl[MODE_SLOW_BIT];
      POWER_CTL.lin_keep <= mode == M_ACTIVE;
    end
  end

  // ---------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  // Data stand for one cycle only and are zero otherwise, so a
  // stale word can never pass for a fresh answer.
  // Unmapped offsets read as zero.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      unique case (ADDR)
        MODE_CTRL_OFS: RDATA <= {28'h0, mode_ctrl};
        WAKE_CFG_OFS: RDATA <= wake_cfg;
        WAKE_FLAG_OFS: RDATA <= wake_flag;
        CYC_CFG_OFS: RDATA <= {15'h0, cyc_on, cyc_ms};
        STATUS_OFS: RDATA <= {28'h0, failsafe, 3'(mode)};
        FAIL_OFS: RDATA <= {24'h0, 1'b0, sup_cnt, 1'b0, wdt_cnt};
        RETAIN0_OFS: RDATA <= retain0;
        RETAIN1_OFS: RDATA <= retain1;
        default: RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

endmodule // system_power_mode_controller

// ### bench/power_mode_props.sv
// Port checker for the power mode controller
`timescale 1ns/1ps
module power_mode_props (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Register writes and rail status
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic CORE_SUPPLY_RAIL_OK,
  // Outputs under watch
  input wire power_mode_pkg::power_ctl_t POWER_CTL,
  input wire power_mode_pkg::mode_t MODE
);
  import power_mode_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------------------------------
  // Mode, supply and command relations
  // ----------------------------------------------------------------
  AST_RESET_HOLD: assert property (
    MODE == M_RESET |-> POWER_CTL.supplies_on && POWER_CTL.hold_init)
    else $error("reset mode without supplies or init hold");
  AST_RAIL_ACTIVE: assert property (
    MODE == M_RESET && CORE_SUPPLY_RAIL_OK |-> ##[1:8] MODE != M_RESET)
    else $error("stable rail did not end reset mode");
  AST_STOP_SUPPLY: assert property (
    MODE == M_STOP |-> !POWER_CTL.pll_on && POWER_CTL.mcu_supply_low
      && POWER_CTL.mcu_supply_on)
    else $error("stop mode supply or PLL setting wrong");
  AST_SLEEP_OFF: assert property (
    MODE == M_SLEEP |-> !POWER_CTL.mcu_supply_on)
    else $error("MCU supply on in sleep");
  AST_ACTIVE_MEASURE: assert property (
    MODE == M_ACTIVE |-> POWER_CTL.measure_on)
    else $error("measurement off in active mode");
  AST_STOP_CMD: assert property (
    WR && ADDR == MODE_CTRL_OFS && WDATA[3:0] == 4'h1 && MODE == M_ACTIVE
      |-> ##[2:4] MODE == M_STOP)
    else $error("stop command not carried out");
  AST_SLOW_CMD: assert property (
    WR && ADDR == MODE_CTRL_OFS && WDATA[3:0] == 4'h4 && MODE == M_ACTIVE
      |-> ##[1:3] POWER_CTL.slow_clock && POWER_CTL.lin_keep)
    else $error("slow-down did not slow clock or keep LIN");
  AST_SLEEP_EXIT: assert property (
    $fell(MODE == M_SLEEP) |-> MODE == M_RESET)
    else $error("sleep left without passing reset mode");
  AST_STOP_EXIT: assert property (
    $fell(MODE == M_STOP) |-> MODE == M_ACTIVE)
    else $error("stop left to a mode other than active");
  // Main paths taken by the bench
  COV_STOP_WAKE: cover property (MODE == M_STOP ##1 MODE == M_ACTIVE);
  COV_SLEEP_WAKE: cover property (MODE == M_SLEEP ##1 MODE == M_RESET);
  COV_SLOW: cover property (POWER_CTL.slow_clock && MODE == M_ACTIVE);
endmodule // power_mode_props

bind system_power_mode_controller power_mode_props i_power_mode_props (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .CORE_SUPPLY_RAIL_OK(CORE_SUPPLY_RAIL_OK),
  .POWER_CTL(POWER_CTL), .MODE(MODE)
);

// ### bench/wake_source_model.sv
// Wake source model: LIN transceiver, monitor pin and GPIO levels
`timescale 1ns/1ps
module wake_source_model (
  // Clock and answer delay
  input wire logic clk,
  input wire logic [3:0] lat,
  // Requested levels
  input wire logic lin_cmd,
  input wire logic mon_cmd,
  input wire logic [3:0] gpio_cmd,
  // Lines to the controller
  output logic lin_wake,
  output logic mon_lvl,
  output logic [3:0] gpio_wake
);
  // ----------------------------------------------------------------
  // Delayed line driver
  // ----------------------------------------------------------------
  logic [5:0] want = 6'h00;
  logic [3:0] cnt = 4'h0;
  // Lines start idle so no wake is seen at power-up
  initial {lin_wake, mon_lvl, gpio_wake} = 6'h00;
  // A new request waits lat cycles; lines move together so that
  // simultaneous wakes really arrive in the same cycle
  always @(posedge clk) begin
    if ({lin_cmd, mon_cmd, gpio_cmd} != want) begin
      want <= {lin_cmd, mon_cmd, gpio_cmd};
      cnt <= lat;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      {lin_wake, mon_lvl, gpio_wake} <= want;
    end
  end
endmodule // wake_source_model

// ### bench/tb_top.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb_top;
  import power_mode_pkg::*;
  // ----------------------------------------------------------------
  // Signals, design and wake sources
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0, reset_n = 1'b0, por_n = 1'b0, wr = 1'b0;
  logic rd = 1'b0, rail_ok = 1'b0, wdt_fail = 1'b0, sup_fail = 1'b0;
  logic lin_cmd = 1'b0, mon_cmd = 1'b0, lin, mon;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] gpio_cmd = 4'h0, gpio, lat = 4'h0;
  power_ctl_t pctl;
  mode_t mode;
  int failures = 0, cmp_count = 0, cycles = 0, seed = 71, n, g, evq[$];
  // Short millisecond keeps the cyclic waits brief
  system_power_mode_controller #(.GPIO_N(4), .MS_CYC(10))
    i_system_power_mode_controller (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .POR_N(por_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CORE_SUPPLY_RAIL_OK(rail_ok), .PRIMARY_WINDOW_WATCHDOG_FAIL(wdt_fail),
    .SUPPLY_FAIL(sup_fail), .LIN_WAKE(lin), .HIGH_VOLTAGE_MONITOR_INPUT(mon),
    .GPIO_WAKE(gpio), .POWER_CTL(pctl), .MODE(mode));
  wake_source_model i_wake_source_model (.clk(ref_clk), .lat(lat),
    .lin_cmd(lin_cmd), .mon_cmd(mon_cmd), .gpio_cmd(gpio_cmd),
    .lin_wake(lin), .mon_lvl(mon), .gpio_wake(gpio));
  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;
  // Cut a hang short; the two one-second fail-safe wakes dominate
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Bounded wait for a mode; a limit of zero checks it at once
  task automatic wait_mode(input mode_t m, input int lim);
    #1 n = 0;
    while (mode !== m && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(32'(mode), 32'(m));
    @(posedge ref_clk);
  endtask
  // Expected supplies, regulator, MCU supply on and low, PLL and
  // measurement per mode
  task automatic chk_pwr(input int m);
    logic [5:0] e;
    case (m)
      0: e = 6'h38;
      1: e = 6'h3B;
      2: e = 6'h3C;
      default: e = 6'h00;
    endcase
    #1 chk({26'h0, pctl.supplies_on, pctl.regulator_on,
      pctl.mcu_supply_on, pctl.mcu_supply_low, pctl.pll_on,
      pctl.measure_on}, {26'h0, e});
  endtask
  // Flags expected from the queued wake events, then cleared
  task automatic clear_flags;
    logic [31:0] e;
    e = 32'h0;
    while (evq.size() > 0) e |= 32'h1 << evq.pop_front();
    rd_chk(WAKE_FLAG_OFS, e);
    rd_chk(WAKE_FLAG_OFS, e);
    wr_reg(WAKE_FLAG_OFS, e);
    rd_chk(WAKE_FLAG_OFS, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    chk_pwr(0);
    chk(32'(pctl.hold_init), 32'h1);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    lat <= 4'($random(seed)) & 4'h7;
    g = $random(seed) & 3;
    cyc(10);
    wait_mode(M_RESET, 0);
    rail_ok <= 1'b1;
    wait_mode(M_ACTIVE, 12);
    chk_pwr(1);
    rd_chk(WAKE_CFG_OFS, WAKE_CFG_RESET);
    rd_chk(CYC_CFG_OFS, 32'h0001_FFFF);
    rd_chk(8'h20, 32'h0);
    // Each monitor edge selection; a wrong edge must not wake
    for (int f = 1; f < 4; f++) begin
      mon_cmd <= (f == 1);
      cyc(16);
      wr_reg(WAKE_CFG_OFS, 32'(f << WCFG_EDGE_POS) | 32'h2);
      wr_reg(MODE_CTRL_OFS, 32'h1);
      wait_mode(M_STOP, 8);
      chk_pwr(2);
      mon_cmd <= ~mon_cmd;
      if (f != 3) begin
        cyc(20);
        wait_mode(M_STOP, 0);
        mon_cmd <= ~mon_cmd;
      end
      wait_mode(M_ACTIVE, 30);
      evq.push_back(WFLAG_MON_BIT);
      clear_flags;
    end
    // LIN and a random GPIO in the same cycle out of stop
    wr_reg(WAKE_CFG_OFS, 32'h0F0F);
    wr_reg(MODE_CTRL_OFS, 32'h1);
    wait_mode(M_STOP, 8);
    lin_cmd <= 1'b1;
    gpio_cmd <= 4'h1 << g;
    wait_mode(M_ACTIVE, 30);
    lin_cmd <= 1'b0;
    gpio_cmd <= 4'h0;
    evq.push_back(WFLAG_LIN_BIT);
    evq.push_back(WFLAG_GPIO_POS + g);
    clear_flags;
    // Cyclic stop, cyclic sleep with GPIO held, plain sleep by LIN
    for (int i = 0; i < 3; i++) begin
      rv = $random(seed);
      wr_reg(RETAIN0_OFS, rv);
      wr_reg(RETAIN1_OFS, ~rv);
      wr_reg(CYC_CFG_OFS, (i < 2) ? 32'h0001_0005 : 32'h0);
      gpio_cmd <= (i == 1) ? 4'h1 << g : 4'h0;
      wr_reg(MODE_CTRL_OFS, (i == 0) ? 32'h9 : (i == 1) ? 32'hB : 32'h2);
      wait_mode((i == 0) ? M_STOP : M_SLEEP, 8);
      chk_pwr((i == 0) ? 2 : 3);
      lin_cmd <= (i == 2);
      wait_mode(M_ACTIVE, 80);
      if (i < 2) chk(32'(n >= 40 && n <= 70), 32'h1);
      lin_cmd <= 1'b0;
      gpio_cmd <= 4'h0;
      rd_chk(RETAIN0_OFS, rv);
      rd_chk(RETAIN1_OFS, ~rv);
      evq.push_back((i < 2) ? WFLAG_CYC_BIT : WFLAG_LIN_BIT);
      clear_flags;
    end
    // Five failures of either kind force sleep with safe wake settings
    for (int s = 0; s < 2; s++) begin
      wr_reg(WAKE_CFG_OFS, 32'hC);
      wr_reg(CYC_CFG_OFS, 32'h0);
      for (int k = 1; k < 6; k++) begin
        {sup_fail, wdt_fail} <= 2'b01 << s;
        cyc(6);
        {sup_fail, wdt_fail} <= 2'b00;
        cyc(6);
        if (k == 4) rd_chk(FAIL_OFS, 32'h4 << (4 * s));
      end
      wait_mode(M_SLEEP, 12);
      rd_chk(STATUS_OFS, 32'h0000_000B);
      rd_chk(WAKE_CFG_OFS, 32'hE);
      rd_chk(CYC_CFG_OFS, 32'h0001_0000 | FAILSAFE_WAKE_MS);
      wait_mode(M_ACTIVE, 10100);
      chk(32'(n > 9900), 32'h1);
      rd_chk(FAIL_OFS, 32'h0);
      evq.push_back(WFLAG_CYC_BIT);
      clear_flags;
    end
    wr_reg(MODE_CTRL_OFS, 32'h4);
    cyc(3);
    #1 chk({30'h0, pctl.slow_clock, pctl.lin_keep}, 32'h3);
    wait_mode(M_ACTIVE, 0);
    tally_and_finish;
  end
endmodule // tb_top
